// file: rpw_pkg.sv
/*
  constants, types and state layout of the reset pulse and supervision timer
  assumes a 10 MHz pclk and 32-bit APB with byte addresses
*/
package rpw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 14;
  localparam int unsigned RAILS         = 12;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_RAILSEL = 8'h04;
  localparam logic [7:0] ADDR_DELAY   = 8'h08;
  localparam logic [7:0] ADDR_PULSE   = 8'h0C;
  localparam logic [7:0] ADDR_WDINIT  = 8'h10;
  localparam logic [7:0] ADDR_WDTMO   = 8'h14;
  localparam logic [7:0] ADDR_RECOVER = 8'h18;
  localparam logic [7:0] ADDR_SERVICE = 8'h1C;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_INTSTS  = 8'h24;
  localparam logic [7:0] ADDR_INTMASK = 8'h28;

  localparam int unsigned C_PULSE    = 0;
  localparam int unsigned C_WD_EN    = 1;
  localparam int unsigned C_COUPLED  = 2;
  localparam int unsigned C_SVC_POL  = 3;
  localparam int unsigned C_EXP_POL  = 4;
  localparam int unsigned C_RST_POL  = 5;
  localparam int unsigned C_TRACK    = 6;
  localparam int unsigned C_GIN_POL  = 7;
  localparam int unsigned C_SVC_PIN  = 8;

  localparam int unsigned I_GOOD    = 0;
  localparam int unsigned I_LOST    = 1;
  localparam int unsigned I_EXPIRY  = 2;
  localparam int unsigned I_RELEASE = 3;

  localparam logic [8:0]  CTRL_RST    = 9'h100;
  localparam logic [11:0] RAILSEL_RST = 12'hFFF;
  localparam logic [4:0]  DELAY_RST   = 5'h00;
  localparam logic [15:0] PULSE_RST   = 16'h0064;
  localparam logic [3:0]  WDINIT_RST  = 4'h0;
  localparam logic [15:0] WDTMO_RST   = 16'h03E8;
  localparam logic [15:0] RECOVER_RST = 16'h0064;
  localparam logic [3:0]  MASK_RST    = 4'h0;
  localparam logic        RSTPIN_RST  = 1'b0;
  localparam logic        EXPPIN_RST  = 1'b1;

  localparam logic [4:0]  DELAY_CODE_MAX = 5'h10;
  localparam logic [15:0] WIDTH_MS_MAX   = 16'h7E00;
  localparam logic [15:0] WIDTH_MS_MIN   = 16'h0001;
  localparam logic [20:0] INIT_BASE_MS   = 21'h00064;

  typedef enum logic [2:0] {SR_WAIT_GOOD, SR_ON_DELAY, SR_PULSE, SR_RUN,
                            SR_OFF_DELAY, SR_RECOVER} rpw_sr_e;
  typedef enum logic [1:0] {WD_OFF, WD_INIT, WD_TIMING, WD_EXPIRED} rpw_wd_e;

  typedef struct packed {
    logic [8:0]        ctrl;
    logic [11:0]       rail_sel;
    logic [4:0]        delay_code;
    logic [15:0]       pulse_ms;
    logic [3:0]        init_code;
    logic [15:0]       tmo_ms;
    logic [15:0]       recover_ms;
    logic [3:0]        sts;
    logic [3:0]        mask;
    logic [RAILS-1:0]  rail_m;
    logic [RAILS-1:0]  rail_s;
    logic              svc_m;
    logic              svc_s;
    logic              svc_d;
    logic              gin_m;
    logic              gin_s;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic              rails_ok;
    rpw_sr_e           sr;
    logic [15:0]       sr_cnt;
    rpw_wd_e           wd;
    logic [20:0]       wd_cnt;
    logic              rst_pin;
    logic              exp_pin;
    logic [31:0]       rdata;
    logic              rerr;
  } rpw_state_s;

  localparam rpw_state_s STATE_RST = '{ctrl: CTRL_RST, rail_sel: RAILSEL_RST,
    delay_code: DELAY_RST, pulse_ms: PULSE_RST, init_code: WDINIT_RST,
    tmo_ms: WDTMO_RST, recover_ms: RECOVER_RST, mask: MASK_RST, sr: SR_WAIT_GOOD,
    wd: WD_OFF, rst_pin: RSTPIN_RST, exp_pin: EXPPIN_RST, default: '0};
endpackage

// file: rpw_proc_model.sv
/*
  processor model that services the supervision timer by toggling its pin
  assumes the bench raises svc_on while the processor software is alive
*/
`timescale 1ns/10ps
module rpw_proc_model #(
  parameter int unsigned PERIOD = 6
) (
  input  wire logic pclk,
  input  wire logic svc_on,
  output logic      service_input
);
  int unsigned cnt;
  initial begin
    service_input = 1'b0;
    cnt = 0;
  end
  // toggle well inside the timeout while alive, go silent when hung
  always @(posedge pclk) begin
    if (svc_on) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == PERIOD - 1) begin
        service_input <= ~service_input;
      end
    end
  end
endmodule

// file: rpw_top.sv
/*
  system reset release, reset pulse and supervision timer with an APB slave
  assumes pins arrive asynchronously and a zero-wait APB master on pclk
*/
`timescale 1ns/10ps
module rpw_top #(
  parameter int unsigned TICK_CYCLES = rpw_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] rail_good,
  input  wire logic        service_input,
  input  wire logic        general_input_pin,
  output logic             system_reset_pin,
  output logic             expiry_output,
  output logic             irq
);
  rpw_pkg::rpw_state_s st;
  rpw_pkg::rpw_state_s next_st;
  logic                acc;
  logic                wr;
  logic                svc_bus;
  logic                svc_evt;
  logic                expire_now;
  logic                wd_allow;
  logic                gin_act;
  logic                rst_act;
  logic [3:0]          set_sts;
  logic [3:0]          clr_sts;

  function automatic logic [15:0] delay_ms(input logic [4:0] code);
    logic [4:0] c;
    c = (code > rpw_pkg::DELAY_CODE_MAX) ? rpw_pkg::DELAY_CODE_MAX : code;
    delay_ms = (c == 5'h00) ? 16'h0000 : (16'h0001 << (c - 5'h01));
  endfunction

  function automatic logic [20:0] init_ms(input logic [3:0] code);
    init_ms = (code == 4'h0) ? 21'h000000 : (rpw_pkg::INIT_BASE_MS << (code - 4'h1));
  endfunction

  function automatic logic [15:0] width_ms(input logic [15:0] v);
    if (v < rpw_pkg::WIDTH_MS_MIN) begin
      width_ms = rpw_pkg::WIDTH_MS_MIN;
    end else if (v > rpw_pkg::WIDTH_MS_MAX) begin
      width_ms = rpw_pkg::WIDTH_MS_MAX;
    end else begin
      width_ms = v;
    end
  endfunction

  assign pready  = ce;
  assign pslverr = st.rerr;
  assign prdata  = st.rdata;
  assign system_reset_pin = st.rst_pin;
  assign expiry_output    = st.exp_pin;
  assign irq     = |(st.sts & st.mask);
  assign acc     = psel & penable & ce;
  assign wr      = acc & pwrite & ~st.rerr;
  assign svc_bus = wr & (paddr == rpw_pkg::ADDR_SERVICE);
  // toggle is polarity independent; active level matters only for tracking
  assign svc_evt = svc_bus | (st.ctrl[rpw_pkg::C_SVC_PIN] & (st.svc_s ^ st.svc_d));
  assign gin_act = st.gin_s ~^ st.ctrl[rpw_pkg::C_GIN_POL];
  assign wd_allow = st.ctrl[rpw_pkg::C_WD_EN] & (~st.ctrl[rpw_pkg::C_COUPLED]
                    | st.sr == rpw_pkg::SR_RUN | st.sr == rpw_pkg::SR_RECOVER);
  assign expire_now = wd_allow & (st.wd == rpw_pkg::WD_TIMING) & ~svc_evt
                      & (st.wd_cnt == 21'h000000);

  always_comb begin
    next_st = st;
    set_sts = 4'h0;
    clr_sts = 4'h0;
    rst_act = 1'b0;
    if (ce) begin
      next_st.rail_m = rail_good;
      next_st.rail_s = st.rail_m;
      next_st.svc_m  = service_input;
      next_st.svc_s  = st.svc_m;
      next_st.svc_d  = st.svc_s;
      next_st.gin_m  = general_input_pin;
      next_st.gin_s  = st.gin_m;
      // common millisecond tick
      if (st.tick_cnt == rpw_pkg::TICK_W'(TICK_CYCLES - 1)) begin
        next_st.tick_cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.tick_cnt = st.tick_cnt + rpw_pkg::TICK_W'(1);
        next_st.tick = 1'b0;
      end
      next_st.rails_ok = &(st.rail_s | ~st.rail_sel);
      if (next_st.rails_ok & ~st.rails_ok) begin
        set_sts[rpw_pkg::I_GOOD] = 1'b1;
      end
      if (~next_st.rails_ok & st.rails_ok) begin
        set_sts[rpw_pkg::I_LOST] = 1'b1;
      end

      // supervision timer
      if (!wd_allow) begin
        next_st.wd = rpw_pkg::WD_OFF;
        next_st.wd_cnt = '0;
      end else begin
        unique case (st.wd)
          rpw_pkg::WD_OFF: begin
            next_st.wd = rpw_pkg::WD_INIT;
            next_st.wd_cnt = init_ms(st.init_code);
          end
          rpw_pkg::WD_INIT: begin
            if (svc_evt || st.wd_cnt == 21'h000000) begin
              next_st.wd = rpw_pkg::WD_TIMING;
              next_st.wd_cnt = {5'h00, width_ms(st.tmo_ms)};
            end else if (st.tick) begin
              next_st.wd_cnt = st.wd_cnt - 21'h000001;
            end
          end
          rpw_pkg::WD_TIMING: begin
            if (svc_evt) begin
              next_st.wd_cnt = {5'h00, width_ms(st.tmo_ms)};
            end else if (expire_now) begin
              next_st.wd = rpw_pkg::WD_EXPIRED;
              set_sts[rpw_pkg::I_EXPIRY] = 1'b1;
            end else if (st.tick) begin
              next_st.wd_cnt = st.wd_cnt - 21'h000001;
            end
          end
          rpw_pkg::WD_EXPIRED: begin
            if (svc_evt) begin
              next_st.wd = rpw_pkg::WD_TIMING;
              next_st.wd_cnt = {5'h00, width_ms(st.tmo_ms)};
            end
          end
        endcase
      end

      // system reset sequencing
      unique case (st.sr)
        rpw_pkg::SR_WAIT_GOOD: begin
          if (st.rails_ok) begin
            next_st.sr = rpw_pkg::SR_ON_DELAY;
            next_st.sr_cnt = delay_ms(st.delay_code);
          end
        end
        rpw_pkg::SR_ON_DELAY: begin
          if (!st.rails_ok) begin
            next_st.sr = rpw_pkg::SR_WAIT_GOOD;
          end else if (st.sr_cnt == 16'h0000) begin
            set_sts[rpw_pkg::I_RELEASE] = 1'b1;
            if (st.ctrl[rpw_pkg::C_PULSE]) begin
              next_st.sr = rpw_pkg::SR_PULSE;
              next_st.sr_cnt = width_ms(st.pulse_ms);
            end else begin
              next_st.sr = rpw_pkg::SR_RUN;
            end
          end else if (st.tick) begin
            next_st.sr_cnt = st.sr_cnt - 16'h0001;
          end
        end
        rpw_pkg::SR_PULSE: begin
          if (!st.rails_ok) begin
            next_st.sr = rpw_pkg::SR_WAIT_GOOD;
          end else if (st.sr_cnt == 16'h0000) begin
            next_st.sr = rpw_pkg::SR_RUN;
          end else if (st.tick) begin
            next_st.sr_cnt = st.sr_cnt - 16'h0001;
          end
        end
        rpw_pkg::SR_RUN: begin
          if (expire_now && st.ctrl[rpw_pkg::C_COUPLED]) begin
            next_st.sr = rpw_pkg::SR_RECOVER;
            next_st.sr_cnt = width_ms(st.recover_ms);
          end else if (!st.rails_ok) begin
            if (st.ctrl[rpw_pkg::C_PULSE]) begin
              next_st.sr = rpw_pkg::SR_WAIT_GOOD;
            end else begin
              next_st.sr = rpw_pkg::SR_OFF_DELAY;
              next_st.sr_cnt = delay_ms(st.delay_code);
            end
          end
        end
        rpw_pkg::SR_OFF_DELAY: begin
          if (st.rails_ok) begin
            next_st.sr = rpw_pkg::SR_RUN;
          end else if (st.sr_cnt == 16'h0000) begin
            next_st.sr = rpw_pkg::SR_WAIT_GOOD;
          end else if (st.tick) begin
            next_st.sr_cnt = st.sr_cnt - 16'h0001;
          end
        end
        rpw_pkg::SR_RECOVER: begin
          if (!st.rails_ok) begin
            next_st.sr = rpw_pkg::SR_WAIT_GOOD;
          end else if (st.ctrl[rpw_pkg::C_TRACK] ? gin_act
                                                 : (st.sr_cnt == 16'h0000)) begin
            next_st.sr = rpw_pkg::SR_RUN;
          end else if (st.tick && st.sr_cnt != 16'h0000) begin
            next_st.sr_cnt = st.sr_cnt - 16'h0001;
          end
        end
      endcase

      // pin levels follow the next state so they leave flip-flops
      if (st.ctrl[rpw_pkg::C_PULSE]) begin
        rst_act = next_st.sr == rpw_pkg::SR_PULSE || next_st.sr == rpw_pkg::SR_RECOVER;
      end else begin
        rst_act = next_st.sr == rpw_pkg::SR_WAIT_GOOD || next_st.sr == rpw_pkg::SR_ON_DELAY
                  || next_st.sr == rpw_pkg::SR_RECOVER;
      end
      next_st.rst_pin = rst_act ~^ st.ctrl[rpw_pkg::C_RST_POL];
      next_st.exp_pin = ~((next_st.wd == rpw_pkg::WD_EXPIRED)
                          & ~st.ctrl[rpw_pkg::C_COUPLED]) ^ st.ctrl[rpw_pkg::C_EXP_POL];

      // APB: decode and read data captured in the setup cycle
      if (psel && !penable) begin
        next_st.rerr = 1'b0;
        unique case (paddr)
          rpw_pkg::ADDR_CTRL:    next_st.rdata = {23'h000000, st.ctrl};
          rpw_pkg::ADDR_RAILSEL: next_st.rdata = {20'h00000, st.rail_sel};
          rpw_pkg::ADDR_DELAY:   next_st.rdata = {27'h0000000, st.delay_code};
          rpw_pkg::ADDR_PULSE:   next_st.rdata = {16'h0000, st.pulse_ms};
          rpw_pkg::ADDR_WDINIT:  next_st.rdata = {28'h0000000, st.init_code};
          rpw_pkg::ADDR_WDTMO:   next_st.rdata = {16'h0000, st.tmo_ms};
          rpw_pkg::ADDR_RECOVER: next_st.rdata = {16'h0000, st.recover_ms};
          rpw_pkg::ADDR_SERVICE: next_st.rdata = 32'h00000000;
          rpw_pkg::ADDR_STATUS:  next_st.rdata = {8'h00, st.rail_s, gin_act, st.svc_s,
                                   st.exp_pin, st.rst_pin, st.rails_ok, 1'b0, st.wd,
                                   1'b0, st.sr};
          rpw_pkg::ADDR_INTSTS:  next_st.rdata = {28'h0000000, st.sts};
          rpw_pkg::ADDR_INTMASK: next_st.rdata = {28'h0000000, st.mask};
          default: begin
            next_st.rdata = 32'h00000000;
            next_st.rerr = 1'b1;
          end
        endcase
      end
      if (wr) begin
        unique case (paddr)
          rpw_pkg::ADDR_CTRL:    next_st.ctrl = pwdata[8:0];
          rpw_pkg::ADDR_RAILSEL: next_st.rail_sel = pwdata[11:0];
          rpw_pkg::ADDR_DELAY:   next_st.delay_code = pwdata[4:0];
          rpw_pkg::ADDR_PULSE:   next_st.pulse_ms = pwdata[15:0];
          rpw_pkg::ADDR_WDINIT:  next_st.init_code = pwdata[3:0];
          rpw_pkg::ADDR_WDTMO:   next_st.tmo_ms = pwdata[15:0];
          rpw_pkg::ADDR_RECOVER: next_st.recover_ms = pwdata[15:0];
          rpw_pkg::ADDR_INTSTS:  clr_sts = pwdata[3:0];
          rpw_pkg::ADDR_INTMASK: next_st.mask = pwdata[3:0];
          default: ;
        endcase
      end
      // a new event beats a simultaneous write-one-to-clear
      next_st.sts = (st.sts & ~clr_sts) | set_sts;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= rpw_pkg::STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence release_step;
    st.sr == rpw_pkg::SR_ON_DELAY && st.rails_ok && st.sr_cnt == 16'h0000 && ce;
  endsequence
  sequence expire_step;
    expire_now && st.ctrl[rpw_pkg::C_COUPLED] && st.sr == rpw_pkg::SR_RUN && ce;
  endsequence

  held_reset_a: assert property (
      (st.sr == rpw_pkg::SR_WAIT_GOOD && !st.ctrl[rpw_pkg::C_PULSE]
      && !st.ctrl[rpw_pkg::C_RST_POL] && $past(ce) && $stable(st.ctrl)
      && $past(st.sr) == rpw_pkg::SR_WAIT_GOOD) |-> !st.rst_pin)
      else $error("reset released before rails good");
  delay_end_a: assert property (release_step |=>
      (st.sr == rpw_pkg::SR_RUN || st.sr == rpw_pkg::SR_PULSE) && st.sts[rpw_pkg::I_RELEASE])
      else $error("release delay did not end");
  level_loss_a: assert property ((st.sr == rpw_pkg::SR_RUN && !st.rails_ok && ce
      && !st.ctrl[rpw_pkg::C_PULSE] && !expire_now) |=> st.sr == rpw_pkg::SR_OFF_DELAY
      && st.sr_cnt == delay_ms(st.delay_code)) else $error("rail loss not handled");
  pulse_start_a: assert property ((release_step and st.ctrl[rpw_pkg::C_PULSE]) |=>
      st.sr == rpw_pkg::SR_PULSE && st.sr_cnt == width_ms(st.pulse_ms)
      && st.sr_cnt >= rpw_pkg::WIDTH_MS_MIN) else $error("pulse width not loaded");
  pulse_end_a: assert property ((st.sr == rpw_pkg::SR_PULSE && st.rails_ok && ce
      && st.sr_cnt == 16'h0000) |=> st.sr == rpw_pkg::SR_RUN)
      else $error("reset pulse did not end");
  off_end_a: assert property ((st.sr == rpw_pkg::SR_OFF_DELAY && !st.rails_ok && ce
      && !st.ctrl[rpw_pkg::C_PULSE] && st.sr_cnt == 16'h0000)
      |=> st.sr == rpw_pkg::SR_WAIT_GOOD && st.rst_pin == st.ctrl[rpw_pkg::C_RST_POL])
      else $error("reset not reasserted");
  svc_reload_a: assert property ((st.wd == rpw_pkg::WD_TIMING && svc_evt
      && wd_allow && ce) |=> st.wd == rpw_pkg::WD_TIMING
      && st.wd_cnt == {5'h00, width_ms(st.tmo_ms)})
      else $error("service did not restart count");
  init_load_a: assert property ((st.wd == rpw_pkg::WD_OFF && wd_allow && ce) |=>
      st.wd == rpw_pkg::WD_INIT && st.wd_cnt == init_ms(st.init_code))
      else $error("initial wait not loaded");
  init_end_a: assert property ((st.wd == rpw_pkg::WD_INIT && wd_allow && ce
      && st.wd_cnt == 21'h000000) |=> st.wd == rpw_pkg::WD_TIMING)
      else $error("initial wait did not end");
  expire_cycle_a: assert property (expire_step |=> st.sr == rpw_pkg::SR_RECOVER
      && st.wd == rpw_pkg::WD_EXPIRED) else $error("expiry did not cycle reset");
  expiry_pin_a: assert property ((expire_now && ce && !st.ctrl[rpw_pkg::C_COUPLED])
      |=> st.exp_pin == st.ctrl[rpw_pkg::C_EXP_POL]) else $error("expiry output not active");
  stay_expired_a: assert property ((st.wd == rpw_pkg::WD_EXPIRED && !svc_evt
      && wd_allow) |=> st.wd == rpw_pkg::WD_EXPIRED)
      else $error("timer resumed without service");
  recover_end_a: assert property ((st.sr == rpw_pkg::SR_RECOVER && st.rails_ok && ce
      && !st.ctrl[rpw_pkg::C_TRACK] && st.sr_cnt == 16'h0000) |=> st.sr == rpw_pkg::SR_RUN)
      else $error("recovery release missed");
  track_end_a: assert property ((st.sr == rpw_pkg::SR_RECOVER && st.rails_ok && ce
      && st.ctrl[rpw_pkg::C_TRACK] && gin_act) |=> st.sr == rpw_pkg::SR_RUN)
      else $error("tracking release missed");
  edge_service_a: assert property ((st.ctrl[rpw_pkg::C_SVC_PIN] && ce && wd_allow
      && st.wd == rpw_pkg::WD_TIMING && st.svc_s != st.svc_d) |=> st.wd == rpw_pkg::WD_TIMING
      && st.wd_cnt == {5'h00, width_ms(st.tmo_ms)}) else $error("service edge missed");
  tick_gap_a: assert property ((st.tick && ce && TICK_CYCLES > 1) |=> !st.tick)
      else $error("tick wider than one cycle");
  hold_state_a: assert property (!ce |=> $stable(st))
      else $error("state moved with ce low");
  sticky_set_a: assert property ((ce && set_sts[rpw_pkg::I_EXPIRY])
      |=> st.sts[rpw_pkg::I_EXPIRY]) else $error("expiry event not latched");
endmodule

// file: rpw_top_bench.sv
/*
  self-checking bench for the reset pulse and supervision timer
  assumes rpw_top with a 4-cycle tick and the processor model beside it
*/
`timescale 1ns/10ps
module rpw_top_bench;
  localparam int unsigned TCK = 4;
  logic        pclk, presetn, ce, psel, penable, pwrite, svc_on, gin, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sys_rst, exp_out, irq, service_input;
  logic [11:0] rail_good;
  int          bad_count, total_checks;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h28};
  logic [31:0] rv [8] = '{32'h100, 32'hFFF, 32'h0, 32'h64, 32'h0, 32'h3E8, 32'h64, 32'h0};

  rpw_top #(.TICK_CYCLES(TCK)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rail_good(rail_good),
    .service_input(service_input), .general_input_pin(gin),
    .system_reset_pin(sys_rst), .expiry_output(exp_out), .irq(irq));

  rpw_proc_model proc (.pclk(pclk), .svc_on(svc_on), .service_input(service_input));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // count cycles until the chosen pin reaches v; bounded by hi
  task automatic wait_pin(input int s, input logic v, input int lo, input int hi);
    int   n;
    logic p;
    n = 0;
    p = ~v;
    while (p !== v && n <= hi) begin
      @(posedge pclk);
      #1;
      n++;
      p = (s == 0) ? sys_rst : exp_out;
    end
    total_checks++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, n, hi);
    end
    // a pin that never arrives ends the run
    if (n > hi) begin
      final_report();
    end
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rail_good = 12'h000;
    gin = 1'b0;
    svc_on = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    chkb(sys_rst, 1'b0);
    chkb(exp_out, 1'b1);
    chkb(irq, 1'b0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h2C, 32'h0);
    chkb(err, 1'b1);
    chk(rd, 32'h0);
    // level mode, rails 3..0 selected, 4 ms delay
    apb(1'b1, 8'h04, 32'h00F);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h28, 32'h1);
    rail_good <= 12'hFFE;
    idle(40);
    chkb(sys_rst, 1'b0);
    chkb(irq, 1'b0);
    rail_good <= 12'h00F;
    wait_pin(0, 1'b1, 12, 24);
    chkb(irq, 1'b1);
    apb(1'b1, 8'h24, 32'h1);
    idle(1);
    chkb(irq, 1'b0);
    rail_good <= 12'h00E;
    wait_pin(0, 1'b0, 12, 24);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'hA);
    apb(1'b1, 8'h24, 32'hF);
    // pulse mode with active-high reset, 2 ms wide
    apb(1'b1, 8'h00, 32'h121);
    apb(1'b1, 8'h0C, 32'h2);
    idle(2);
    chkb(sys_rst, 1'b0);
    rail_good <= 12'h00F;
    wait_pin(0, 1'b1, 12, 24);
    wait_pin(0, 1'b0, 4, 16);
    idle(40);
    chkb(sys_rst, 1'b0);
    // standalone timer, 3 ms timeout, serviced by pin toggles
    apb(1'b1, 8'h14, 32'h3);
    svc_on <= 1'b1;
    apb(1'b1, 8'h00, 32'h102);
    idle(100);
    chkb(exp_out, 1'b1);
    chkb(sys_rst, 1'b1);
    svc_on <= 1'b0;
    wait_pin(1, 1'b0, 2, 24);
    idle(60);
    chkb(exp_out, 1'b0);
    chkb(sys_rst, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'hD);
    chkb(irq, 1'b1);
    // clear the pending good event; masked expiry and release events keep irq low
    apb(1'b1, 8'h24, 32'h1);
    idle(1);
    chkb(irq, 1'b0);
    apb(1'b1, 8'h1C, 32'h1);
    wait_pin(1, 1'b1, 0, 4);
    wait_pin(1, 1'b0, 6, 20);
    // coupled timer: expiry cycles the reset for 2 ms
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h00, 32'h106);
    apb(1'b1, 8'h1C, 32'h1);
    wait_pin(0, 1'b0, 2, 20);
    wait_pin(0, 1'b1, 4, 16);
    chkb(exp_out, 1'b1);
    idle(40);
    chkb(sys_rst, 1'b1);
    // coupled timer with release tracking the general input
    apb(1'b1, 8'h00, 32'h1C6);
    apb(1'b1, 8'h1C, 32'h1);
    wait_pin(0, 1'b0, 2, 20);
    idle(40);
    chkb(sys_rst, 1'b0);
    gin <= 1'b1;
    wait_pin(0, 1'b1, 0, 8);
    // clock enable low freezes all state even when rails drop
    ce <= 1'b0;
    rail_good <= 12'h000;
    idle(20);
    chkb(pready, 1'b0);
    chkb(sys_rst, 1'b1);
    ce <= 1'b1;
    // mid-run reset returns everything to its reset values
    presetn <= 1'b0;
    idle(2);
    chkb(sys_rst, 1'b0);
    chkb(exp_out, 1'b1);
    chkb(irq, 1'b0);
    presetn <= 1'b1;
    idle(2);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd & 32'hFFFFFBFF, 32'h00000200);
    final_report();
  end
endmodule
